// [logic/sensor_regs.vh]
`ifndef SENSOR_REGS_VH
`define SENSOR_REGS_VH

// register pointer values
`define TEMP_RESULT_PTR   8'h05
`define MAKER_ID_PTR      8'h06
`define PART_ID_PTR       8'h07
`define BUS_OPTIONS_PTR   8'h08

// temperature word field positions
`define CRIT_BIT          15
`define OVER_BIT          14
`define UNDER_BIT         13
`define SIGN_BIT          12

// bus option field positions and reset values
`define TIMEOUT_DIS_BIT   7
`define ALERT_DIS_BIT     0
`define TIMEOUT_DIS_RST   1'b0
`define ALERT_DIS_RST     1'b0

// identification values, arbitrary
`define MAKER_ID_VALUE    16'h5A3C
`define PART_CODE_VALUE   8'h6E
`define PART_REV_VALUE    8'h03

// upper four bits of the seven-bit bus address
`define BUS_ADDR_HI       4'h3

// timing
`define CLK_KHZ           10000
`define TIMEOUT_MS        25
// 25 ms of the 10 MHz clock, sized for the time-out counter
`define TIMEOUT_CYCLES_DEF 18'd250000

`endif

// [logic/pin_sync.v]
`timescale 1ns/100ps
module pin_sync #(
    parameter WIDTH = 1
) (
    // clock and reset
    input  wire             clk,
    input  wire             reset_n,
    // pins and synchronised copies
    input  wire [WIDTH-1:0] pin_in,
    output wire [WIDTH-1:0] pin_sync_out
);

    reg [WIDTH-1:0] meta_reg;
    reg [WIDTH-1:0] sync_reg;

    // idle bus lines are high, so reset to one to avoid a false start
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            always @(posedge clk) begin
                if (!reset_n) begin
                    meta_reg[i] <= 1'b1;
                    sync_reg[i] <= 1'b1;
                end else begin
                    meta_reg[i] <= pin_in[i];
                    sync_reg[i] <= meta_reg[i];
                end
            end
        end
    endgenerate

    assign pin_sync_out = sync_reg;

endmodule

// [logic/thermal_status_id_regs.v]
// What this block does
// - critical flag bit 15 set at or above critical threshold, else clear
// - over-window flag bit 14 set above upper threshold, else clear
// - under-window flag bit 13 set below lower threshold, else clear
// - temperature two's complement, bits 11:1 at 0.125 C, sign bit 12
// - temperature word read-only, writes ignored, resets to zero
// - read-only 16-bit maker identification word with fixed code
// - read-only word: part code upper byte, revision lower byte
// - bus option bit 7 at 0 enables bus time-out, 1 disables
// - bus option bit 0 only drives bus_alert_disable out; the event output ignores it
// - option bit writes ignored while either lock bit is set
// - event output asserted when temperature passes alarm thresholds
// - device is only a slave; host starts every transaction
// - thresholds two's complement, bit 2 is 0.25 C, aligned to result
// - comparisons always use the thresholds currently programmed
`timescale 1ns/100ps
`include "sensor_regs.vh"
module thermal_status_id_regs #(
    parameter [17:0] TIMEOUT_CYCLES = `TIMEOUT_CYCLES_DEF
) (
    // clock and reset
    input  wire        clk,
    input  wire        reset_n,
    // two-wire bus pins
    input  wire        scl_in,
    input  wire        sda_in,
    output wire        sda_out,
    output wire        sda_oe,
    input  wire [2:0]  addr_pins,
    // event pin, open drain, active low
    output wire        event_n_out,
    output wire        event_oe,
    // converter result, two's complement, lsb 0.125 C
    input  wire [11:0] temp_sample,
    input  wire        temp_valid,
    // thresholds and locks from the configuration logic
    input  wire [15:0] upper_threshold,
    input  wire [15:0] lower_threshold,
    input  wire [15:0] critical_threshold,
    input  wire        critical_lock,
    input  wire        window_lock,
    // bus option bits
    output wire        bus_timeout_disable,
    output wire        bus_alert_disable
);

    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_RECV = 3'd1;
    localparam [2:0] ST_SACK = 3'd2;
    localparam [2:0] ST_SEND = 3'd3;
    localparam [2:0] ST_MACK = 3'd4;

    wire [4:0] sync_bus;
    wire       scl_s;
    wire       sda_s;
    wire [2:0] addr_s;

    pin_sync #(
        .WIDTH        (5)
    ) u_sync (
        .clk          (clk),
        .reset_n      (reset_n),
        .pin_in       ({addr_pins, sda_in, scl_in}),
        .pin_sync_out (sync_bus)
    );

    assign scl_s  = sync_bus[0];
    assign sda_s  = sync_bus[1];
    assign addr_s = sync_bus[4:2];

    reg        scl_d_reg;
    reg        sda_d_reg;
    reg [2:0]  state_reg;
    reg [1:0]  phase_reg;
    reg [3:0]  bit_cnt_reg;
    reg [7:0]  shift_reg;
    reg [7:0]  ptr_reg;
    reg [7:0]  msb_reg;
    reg        is_read_reg;
    reg        rd_lo_reg;
    reg [15:0] word_latch_reg;
    reg        sda_oe_reg;
    reg [17:0] tmo_cnt_reg;
    reg [12:1] temp_reg;
    reg        crit_reg;
    reg        over_reg;
    reg        under_reg;
    reg        event_reg;
    reg        tmo_dis_reg;
    reg        alert_dis_reg;
    reg [15:0] read_word;

    wire scl_rise  = scl_s & ~scl_d_reg;
    wire scl_fall  = ~scl_s & scl_d_reg;
    wire start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    wire stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
    wire tmo_hit   = (tmo_cnt_reg == TIMEOUT_CYCLES - 18'h00001);
    wire locked    = critical_lock | window_lock;

    // threshold lsb is 0.25 C, so pad a zero to meet the 0.125 C result
    wire signed [11:0] temp_val  = temp_reg;
    wire signed [11:0] upper_val = {upper_threshold[12:2], 1'b0};
    wire signed [11:0] lower_val = {lower_threshold[12:2], 1'b0};
    wire signed [11:0] crit_val  = {critical_threshold[12:2], 1'b0};

    // temperature word: flags, sign and value, bit 0 reserved
    wire [15:0] temp_word = {crit_reg, over_reg, under_reg, temp_reg, 1'b0};

    always @* begin
        case (ptr_reg)
            `TEMP_RESULT_PTR: read_word = temp_word;
            `MAKER_ID_PTR:    read_word = `MAKER_ID_VALUE;
            `PART_ID_PTR:     read_word = {`PART_CODE_VALUE,
                                           `PART_REV_VALUE};
            `BUS_OPTIONS_PTR: read_word = {8'h00, tmo_dis_reg, 6'h00,
                                           alert_dis_reg};
            default:          read_word = 16'h0000;
        endcase
    end

    // converter result and comparison flags
    always @(posedge clk) begin
        if (!reset_n) begin
            temp_reg  <= 12'h000;
            crit_reg  <= 1'b0;
            over_reg  <= 1'b0;
            under_reg <= 1'b0;
            event_reg <= 1'b0;
        end else begin
            if (temp_valid) begin
                temp_reg <= temp_sample;
            end
            // compared every cycle, so threshold edits act on the next clock
            crit_reg  <= (temp_val >= crit_val);
            over_reg  <= (temp_val > upper_val);
            under_reg <= (temp_val < lower_val);
            event_reg <= (temp_val >= crit_val) | (temp_val > upper_val)
                         | (temp_val < lower_val);
        end
    end

    // bus time-out: a host holding scl low too long frees the bus
    always @(posedge clk) begin
        if (!reset_n) begin
            tmo_cnt_reg <= 18'h00000;
        end else if (state_reg == ST_IDLE || scl_s || tmo_dis_reg ||
                     tmo_hit) begin
            tmo_cnt_reg <= 18'h00000;
        end else begin
            tmo_cnt_reg <= tmo_cnt_reg + 18'h00001;
        end
    end

    // slave byte engine; it never starts a transfer itself
    always @(posedge clk) begin
        if (!reset_n) begin
            scl_d_reg      <= 1'b1;
            sda_d_reg      <= 1'b1;
            state_reg      <= ST_IDLE;
            phase_reg      <= 2'd0;
            bit_cnt_reg    <= 4'h0;
            shift_reg      <= 8'h00;
            ptr_reg        <= 8'h00;
            msb_reg        <= 8'h00;
            is_read_reg    <= 1'b0;
            rd_lo_reg      <= 1'b0;
            word_latch_reg <= 16'h0000;
            sda_oe_reg     <= 1'b0;
            tmo_dis_reg    <= `TIMEOUT_DIS_RST;
            alert_dis_reg  <= `ALERT_DIS_RST;
        end else begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
            if (start_det) begin
                state_reg   <= ST_RECV;
                phase_reg   <= 2'd0;
                bit_cnt_reg <= 4'h0;
                sda_oe_reg  <= 1'b0;
            end else if (stop_det || tmo_hit) begin
                state_reg  <= ST_IDLE;
                sda_oe_reg <= 1'b0;
            end else begin
                case (state_reg)
                    ST_RECV: begin
                        if (scl_rise) begin
                            shift_reg   <= {shift_reg[6:0], sda_s};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end else if (scl_fall && bit_cnt_reg == 4'h8) begin
                            bit_cnt_reg <= 4'h0;
                            sda_oe_reg  <= 1'b1;
                            state_reg   <= ST_SACK;
                            case (phase_reg)
                                2'd0: begin
                                    is_read_reg <= shift_reg[0];
                                    if (shift_reg[7:1] !=
                                        {`BUS_ADDR_HI, addr_s}) begin
                                        sda_oe_reg <= 1'b0;
                                        state_reg  <= ST_IDLE;
                                    end
                                end
                                2'd1: ptr_reg <= shift_reg;
                                2'd2: msb_reg <= shift_reg;
                                default: begin
                                    // only the option bits take writes
                                    if (ptr_reg == `BUS_OPTIONS_PTR &&
                                        !locked) begin
                                        tmo_dis_reg   <=
                                            shift_reg[`TIMEOUT_DIS_BIT];
                                        alert_dis_reg <=
                                            shift_reg[`ALERT_DIS_BIT];
                                    end
                                end
                            endcase
                        end
                    end
                    ST_SACK: begin
                        if (scl_fall) begin
                            if (is_read_reg && phase_reg == 2'd0) begin
                                // whole word latched so both bytes agree
                                word_latch_reg <= read_word;
                                shift_reg      <= read_word[15:8];
                                sda_oe_reg     <= ~read_word[15];
                                rd_lo_reg      <= 1'b0;
                                state_reg      <= ST_SEND;
                            end else begin
                                sda_oe_reg <= 1'b0;
                                state_reg  <= ST_RECV;
                                phase_reg  <= (phase_reg == 2'd3) ?
                                              2'd2 : phase_reg + 2'd1;
                            end
                        end
                    end
                    ST_SEND: begin
                        if (scl_fall) begin
                            if (bit_cnt_reg == 4'h7) begin
                                bit_cnt_reg <= 4'h0;
                                sda_oe_reg  <= 1'b0;
                                state_reg   <= ST_MACK;
                            end else begin
                                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                                shift_reg   <= {shift_reg[6:0], 1'b0};
                                sda_oe_reg  <= ~shift_reg[6];
                            end
                        end
                    end
                    ST_MACK: begin
                        if (scl_rise && sda_s) begin
                            state_reg <= ST_IDLE;
                        end else if (scl_fall) begin
                            state_reg <= ST_SEND;
                            if (rd_lo_reg) begin
                                word_latch_reg <= read_word;
                                shift_reg      <= read_word[15:8];
                                sda_oe_reg     <= ~read_word[15];
                                rd_lo_reg      <= 1'b0;
                            end else begin
                                shift_reg  <= word_latch_reg[7:0];
                                sda_oe_reg <= ~word_latch_reg[7];
                                rd_lo_reg  <= 1'b1;
                            end
                        end
                    end
                    default: state_reg <= ST_IDLE;
                endcase
            end
        end
    end

    assign sda_out             = 1'b0;
    assign sda_oe              = sda_oe_reg;
    assign event_n_out         = 1'b0;
    assign event_oe            = event_reg;
    assign bus_timeout_disable = tmo_dis_reg;
    assign bus_alert_disable   = alert_dis_reg;

endmodule

// [testbench/thermal_status_id_regs_props.sv]
`timescale 1ns/100ps
module thermal_status_id_regs_props #(
    parameter int TIMEOUT_CYCLES = 250000
) (
    // clock and reset
    input wire        clk,
    input wire        reset_n,
    // pins
    input wire        scl_in,
    input wire        sda_out,
    input wire        sda_oe,
    input wire        event_n_out,
    input wire        event_oe,
    // sensor side
    input wire [11:0] temp_sample,
    input wire        temp_valid,
    input wire [15:0] upper_threshold,
    input wire [15:0] lower_threshold,
    input wire [15:0] critical_threshold,
    input wire        critical_lock,
    input wire        window_lock,
    // option bits
    input wire        bus_timeout_disable,
    input wire        bus_alert_disable
);
    reg        [11:0] t_reg;
    wire signed [12:0] t_val = {t_reg, 1'b0};
    wire crit = t_val >= $signed(critical_threshold[12:0]);
    wire over = t_val > $signed(upper_threshold[12:0]);
    wire under = t_val < $signed(lower_threshold[12:0]);
    wire lock = critical_lock | window_lock;
    wire [1:0] opts = {bus_timeout_disable, bus_alert_disable};
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // mirror of the held sample, so flags can be predicted from ports
    always @(posedge clk) begin
        if (!reset_n)
            t_reg <= 12'h000;
        else if (temp_valid)
            t_reg <= temp_sample;
    end
    // cycles the device has held data low under a stopped clock
    reg [17:0] stall_cnt;
    always @(posedge clk) begin
        if (!reset_n || scl_in || !sda_oe || bus_timeout_disable)
            stall_cnt <= 18'h00000;
        else
            stall_cnt <= stall_cnt + 18'h00001;
    end
    a_crit_event: assert property (
        $past(reset_n) && $past(crit) |-> event_oe)
        else $error("critical level without event");
    a_over_event: assert property (
        $past(reset_n) && $past(over) |-> event_oe)
        else $error("over window without event");
    a_under_event: assert property (
        $past(reset_n) && $past(under) |-> event_oe)
        else $error("under window without event");
    a_event_quiet: assert property (
        $past(reset_n) && !$past(crit | over | under) |-> !event_oe)
        else $error("event without cause");
    a_opt_locked: assert property (
        lock && $past(lock) |-> $stable(opts))
        else $error("option bits changed while locked");
    a_reset_clear: assert property (
        !$past(reset_n) |-> !sda_oe && !event_oe && opts == 2'b00)
        else $error("outputs not cleared by reset");
    a_fixed_low: assert property (
        sda_out == 1'b0 && event_n_out == 1'b0)
        else $error("open drain data not low");
    a_oe_scl_low: assert property (
        $changed(sda_oe) |-> !$past(scl_in, 3))
        else $error("data line moved during clock high");
    a_tmo_release: assert property (
        stall_cnt <= TIMEOUT_CYCLES + 3)
        else $error("data held past the bus time-out");
    a_idle_quiet: assert property (
        scl_in [*8] |-> !sda_oe)
        else $error("data pulled while the clock stands high");
    c_crit: cover property (event_oe && crit);
    c_alert_off: cover property ($rose(bus_alert_disable));
    c_ack: cover property ($rose(sda_oe));
    c_stall: cover property (stall_cnt == 18'd100);
endmodule
bind thermal_status_id_regs thermal_status_id_regs_props #(
    .TIMEOUT_CYCLES(TIMEOUT_CYCLES)) chk (
    .clk(clk), .reset_n(reset_n), .scl_in(scl_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .event_n_out(event_n_out), .event_oe(event_oe),
    .temp_sample(temp_sample), .temp_valid(temp_valid),
    .upper_threshold(upper_threshold), .lower_threshold(lower_threshold),
    .critical_threshold(critical_threshold),
    .critical_lock(critical_lock), .window_lock(window_lock),
    .bus_timeout_disable(bus_timeout_disable),
    .bus_alert_disable(bus_alert_disable));

// [testbench/smbus_host.sv]
`timescale 1ns/100ps
module smbus_host (
    // bus pins, pulled up when released
    output reg        scl,
    output reg        sda_pull,
    input  wire       sda_line,
    // completed read word
    output reg [15:0] rd_word,
    output reg        rd_done
);
    reg [7:0] got;
    reg       ack;
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
        rd_word = 16'h0000;
        rd_done = 1'b0;
    end
    // data moves mid-low, sampled mid-high, clock still between frames
    task bit_io(input b, output r);
        begin
            #200 sda_pull = !b;
            #200 scl = 1'b1;
            #200 r = sda_line;
            #200 scl = 1'b0;
        end
    endtask
    task xfer(input [7:0] b, input last);
        integer k;
        begin
            for (k = 7; k >= 0; k = k - 1)
                bit_io(b[k], got[k]);
            bit_io(last, ack);
        end
    endtask
    task start;
        begin
            #200 sda_pull = 1'b0;
            #200 scl = 1'b1;
            #400 sda_pull = 1'b1;
            #400 scl = 1'b0;
        end
    endtask
    task stop;
        begin
            #200 sda_pull = 1'b1;
            #200 scl = 1'b1;
            #400 sda_pull = 1'b0;
            #400;
        end
    endtask
    task write_word(input [6:0] a, input [7:0] p, input [15:0] w);
        begin
            #37 start;
            xfer({a, 1'b0}, 1'b1);
            xfer(p, 1'b1);
            xfer(w[15:8], 1'b1);
            xfer(w[7:0], 1'b1);
            stop;
        end
    endtask
    task read_word(input [6:0] a, input [7:0] p, input integer hold);
        begin
            #37 start;
            xfer({a, 1'b0}, 1'b1);
            xfer(p, 1'b1);
            start;
            xfer({a, 1'b1}, 1'b1);
            // scl held low here to stretch the transfer
            if (hold > 0)
                #(hold);
            xfer(8'hFF, 1'b0);
            rd_word[15:8] = got;
            xfer(8'hFF, 1'b1);
            rd_word[7:0] = got;
            stop;
            rd_done = 1'b1;
            #100 rd_done = 1'b0;
        end
    endtask
endmodule

// [testbench/thermal_status_id_regs_bench.sv]
`timescale 1ns/100ps
`include "sensor_regs.vh"
module thermal_status_id_regs_bench;
    reg         clk = 1'b0;
    reg         reset_n = 1'b0;
    reg  [2:0]  addr_pins = 3'h0;
    reg  [11:0] temp_sample = 12'h000;
    reg         temp_valid = 1'b0;
    reg  [15:0] upper_threshold = 16'h0000;
    reg  [15:0] lower_threshold = 16'h0000;
    reg  [15:0] critical_threshold = 16'h0000;
    reg         critical_lock = 1'b0;
    reg         window_lock = 1'b0;
    reg  [11:0] s;
    wire        scl, sda_pull, sda_out, sda_oe, event_n_out, event_oe;
    wire        bus_timeout_disable, bus_alert_disable, rd_done;
    wire [15:0] rd_word;
    wire        sda_line = !(sda_pull | sda_oe);
    integer     fails = 0;
    integer     num_checks = 0;
    integer     i;
    logic [15:0] exp_q[$];
    always #50 clk = ~clk;
    thermal_status_id_regs #(.TIMEOUT_CYCLES(18'd200)) dut (
        .clk(clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .addr_pins(addr_pins),
        .event_n_out(event_n_out), .event_oe(event_oe),
        .temp_sample(temp_sample), .temp_valid(temp_valid),
        .upper_threshold(upper_threshold), .lower_threshold(lower_threshold),
        .critical_threshold(critical_threshold),
        .critical_lock(critical_lock), .window_lock(window_lock),
        .bus_timeout_disable(bus_timeout_disable),
        .bus_alert_disable(bus_alert_disable));
    smbus_host host (.scl(scl), .sda_pull(sda_pull), .sda_line(sda_line),
        .rd_word(rd_word), .rd_done(rd_done));
    task automatic note(input logic [15:0] got, input logic [15:0] exp);
        begin
            num_checks++;
            if (got !== exp) begin
                fails++;
                $display("MISMATCH %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task automatic rd(input [7:0] p, input [15:0] exp);
        begin
            exp_q.push_back(exp);
            host.read_word({`BUS_ADDR_HI, addr_pins}, p, 0);
        end
    endtask
    task automatic wr(input [7:0] p, input [15:0] w);
        host.write_word({`BUS_ADDR_HI, addr_pins}, p, w);
    endtask
    function [15:0] exp_word(input [11:0] v);
        reg signed [12:0] t;
        begin
            t = {v, 1'b0};
            exp_word = {t >= $signed(critical_threshold[12:0]),
                t > $signed(upper_threshold[12:0]),
                t < $signed(lower_threshold[12:0]), v, 1'b0};
        end
    endfunction
    // a read word with no note left counts against the run
    always @(posedge rd_done)
        if (exp_q.size() == 0)
            fails++;
        else
            note(rd_word, exp_q.pop_front());
    task tally_and_finish;
        begin
            fails = fails + exp_q.size();
            if (fails == 0 && num_checks > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    initial begin
        #4000000;
        fails++;
        tally_and_finish;
    end
    initial begin
        void'($urandom(8));
        addr_pins = 3'($urandom);
        repeat (12) @(negedge clk);
        reset_n = 1'b1;
        repeat (4) @(negedge clk);
        rd(`BUS_OPTIONS_PTR, 16'h0000);
        wr(`TEMP_RESULT_PTR, 16'hFFFF);
        rd(`TEMP_RESULT_PTR, exp_word(12'h000));
        rd(`MAKER_ID_PTR, `MAKER_ID_VALUE);
        rd(`PART_ID_PTR, {`PART_CODE_VALUE, `PART_REV_VALUE});
        rd(8'h1F, 16'h0000);
        // a foreign address is neither acked nor answered
        exp_q.push_back(16'hFFFF);
        host.read_word({`BUS_ADDR_HI, ~addr_pins}, `MAKER_ID_PTR, 0);
        for (i = 0; i < 6; i++) begin
            @(negedge clk);
            critical_threshold = 16'($urandom) & 16'h1FFC;
            upper_threshold = 16'($urandom) & 16'h1FFC;
            lower_threshold = 16'($urandom) & 16'h1FFC;
            @(negedge clk);
            s = 12'($urandom);
            // equal values probe each threshold's own boundary
            if (i == 0)
                s = {critical_threshold[12:2], 1'b0};
            if (i == 1)
                s = {upper_threshold[12:2], 1'b0};
            if (i == 2)
                s = {lower_threshold[12:2], 1'b0};
            temp_sample = s;
            temp_valid = 1'b1;
            @(negedge clk);
            temp_valid = 1'b0;
            rd(`TEMP_RESULT_PTR, exp_word(s));
        end
        wr(`BUS_OPTIONS_PTR, 16'hFFFF);
        rd(`BUS_OPTIONS_PTR, 16'h0081);
        note({bus_timeout_disable, bus_alert_disable}, 16'h0003);
        // with the time-out off a long scl low phase must not lose the word
        exp_q.push_back(`MAKER_ID_VALUE);
        host.read_word({`BUS_ADDR_HI, addr_pins}, `MAKER_ID_PTR, 30000);
        for (i = 0; i < 2; i++) begin
            @(negedge clk);
            critical_lock = (i == 0);
            window_lock = (i == 1);
            wr(`BUS_OPTIONS_PTR, 16'h0000);
            rd(`BUS_OPTIONS_PTR, 16'h0081);
        end
        @(negedge clk);
        window_lock = 1'b0;
        wr(`BUS_OPTIONS_PTR, 16'h0001);
        rd(`BUS_OPTIONS_PTR, 16'h0001);
        note({bus_timeout_disable, bus_alert_disable}, 16'h0001);
        // time-out on: the device lets go and the host reads the pull-up
        exp_q.push_back(16'hFFFF);
        host.read_word({`BUS_ADDR_HI, addr_pins}, `MAKER_ID_PTR, 30000);
        repeat (10) @(negedge clk);
        tally_and_finish;
    end
endmodule
